// [dv/ext_periph_model.sv]
// Byte-wide external peripheral with an optional ready pulse.
module ext_periph_model (
  input  wire logic        core_clk_in,
  input  wire logic        sel_act_in,
  input  wire logic        sel_in,
  input  wire logic        cmd_act_high_in,
  input  wire logic        re_in,
  input  wire logic        we_in,
  input  wire logic [7:0]  addr_in,
  input  wire logic [15:0] wdata_in,
  input  wire logic        rdy_go_in,
  input  wire logic        rdy_rise_in,
  output logic      [15:0] rdata_out,
  output logic             ready_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [256];
  logic [3:0] cnt = 4'h0;
  logic       rd;
  logic       wr;
  initial rdata_out = 16'h0;
  assign rd = sel_in == sel_act_in && re_in == cmd_act_high_in;
  assign wr = sel_in == sel_act_in && we_in == cmd_act_high_in;
  // Released lines show the inverse of their last value.
  always @(posedge core_clk_in) begin
    if (wr) begin
      mem[addr_in] <= wdata_in[7:0];
    end
    cnt <= (rd || wr) ? cnt + 4'h1 : 4'h0;
    rdata_out <= rd ? {~rdata_out[15:8], mem[addr_in]} : ~rdata_out;
  end
  assign ready_out = (rdy_go_in && cnt >= 4'h3) ^ ~rdy_rise_in;
endmodule

// [dv/external_peripheral_bus_ctrl_assertions.sv]
// Port-level checks for the external peripheral bus controller.
module external_peripheral_bus_ctrl_assertions #(
  parameter int ADDR_W = 26,
  parameter int NUM_CS = 5
) (
  input  wire logic              core_clk_in,
  input  wire logic              arst_n_in,
  input  wire logic              hsel_in,
  input  wire logic [1:0]        htrans_in,
  input  wire logic              hready_in,
  input  wire logic              hready_out,
  input  wire logic              hresp_out,
  input  wire logic              clk_en_in,
  input  wire logic              clk_hiz_in,
  input  wire logic [NUM_CS-1:0] cs_act_high_in,
  input  wire logic [NUM_CS-1:0] cs_out,
  input  wire logic [ADDR_W-1:0] addr_out,
  input  wire logic              addr_latch_strobe_out,
  input  wire logic              cmd_latch_strobe_out,
  input  wire logic              nand_write_strobe_out,
  input  wire logic              nand_read_strobe_out,
  input  wire logic              exp_clk_out,
  input  wire logic              exp_clk_oe_n_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ************************************************************
  // Checks
  // ************************************************************
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!arst_n_in);
  logic [NUM_CS-1:0] cs_act;
  logic [1:0]        up;
  assign cs_act = ~(cs_out ^ cs_act_high_in);
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      up <= 2'h0;
    end else begin
      up <= {up[0], 1'h1};
    end
  end
  AST_ONE_SEL: assert property (up[1] |-> $onehot0(cs_act))
    else $error("more than one select active");
  AST_STALL: assert property (hsel_in && htrans_in[1] && hready_in && hready_out |=> !hready_out)
    else $error("request did not stall the bus");
  AST_ERR_TWO: assert property (hresp_out && !hready_out |=> hresp_out && hready_out)
    else $error("error response not two cycles");
  AST_SEL_STALL: assert property (up[1] && (|cs_act) |-> !hready_out)
    else $error("select active while bus not stalled");
  AST_END_QUIET: assert property ($rose(hready_out) |-> cs_act == '0)
    else $error("select still active at completion");
  AST_NAND_ONE: assert property (nand_write_strobe_out || nand_read_strobe_out)
    else $error("both nand strobes active");
  AST_NAND_LATCH: assert property (!nand_write_strobe_out |->
      addr_latch_strobe_out == addr_out[9] && cmd_latch_strobe_out == addr_out[10])
    else $error("nand latch strobes do not follow address");
  AST_CLK_HIZ: assert property (clk_hiz_in [*3] |-> exp_clk_oe_n_out)
    else $error("expansion clock driven while floated");
  AST_CLK_OFF: assert property (!clk_en_in [*3] |-> !exp_clk_out)
    else $error("expansion clock running while off");
  cover property ($rose(hready_out) && hresp_out);
  cover property (!nand_write_strobe_out);
  cover property ($fell(hready_out));
endmodule

bind external_peripheral_bus_ctrl external_peripheral_bus_ctrl_assertions #(
  .ADDR_W(ADDR_W), .NUM_CS(NUM_CS)) external_peripheral_bus_ctrl_assertions_inst (.*);

// [dv/external_peripheral_bus_ctrl_tb.sv]
// Self-checking bench for the external peripheral bus controller.
module external_peripheral_bus_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk_in = 0, arst_n_in = 0, hsel_in = 0, hwrite_in = 0, hready_in = 1;
  logic clk_en_in = 1, clk_hiz_in = 0, rdy_rise_in, nand_mode_in = 0, cs4_en_in, rdy_go = 0;
  logic cmd_act_high_in, dir_act_high_in, ready_in, hready_out, hresp_out, data_oe_n_out, re_out;
  logic we_out, ale_out, nand_select_pin_out, addr_latch_strobe_out, cmd_latch_strobe_out;
  logic nand_write_strobe_out, nand_read_strobe_out, exp_clk_out, exp_clk_oe_n_out, err;
  logic [1:0]  htrans_in = 0, boot_width_in = 0, byte_en_out;
  logic [2:0]  hsize_in = 0;
  logic [3:0]  clk_div_in, setup_cnt_in, width_cnt_in, hold_cnt_in;
  logic [4:0]  cs_act_high_in, wide16_in = 0, ale_mode_in = 0, strobe_select_bit_in = 0;
  logic [4:0]  rdy_en_in = 0, cs_out;
  logic [15:0] data_in, data_out;
  logic [25:0] addr_out;
  logic [31:0] haddr_in = 0, hwdata_in = 0, hrdata_out, rd, w, a;
  logic [39:0] cs_base_in = 40'h0403020100, cs_top_in = 40'h0403020100;
  int          n_mismatch = 0, n_tests = 0, ncyc, b;
  assign cs4_en_in = ~nand_mode_in;
  external_peripheral_bus_ctrl external_peripheral_bus_ctrl_inst (.*);
  ext_periph_model ext_periph_model_inst (.core_clk_in, .sel_act_in(cs_act_high_in[1]),
    .sel_in(cs_out[1]), .cmd_act_high_in, .re_in(re_out), .we_in(we_out),
    .addr_in(addr_out[7:0]), .wdata_in(data_out), .rdy_go_in(rdy_go), .rdy_rise_in,
    .rdata_out(data_in), .ready_out(ready_in));
  // ************************************************************
  // Tasks
  // ************************************************************
  initial forever #5 core_clk_in = ~core_clk_in;
  function automatic logic [31:0] rep(logic [7:0] v);
    return {4{v}};
  endfunction
  task automatic print_verdict();
    $display("mismatches %0d of %0d checks", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cfg(logic [3:0] wid, logic [3:0] div);
    clk_div_in = div;
    setup_cnt_in = 4'h1 + 4'($urandom % 3);
    hold_cnt_in = 4'h1 + 4'($urandom % 3);
    width_cnt_in = wid;
  endtask
  task automatic ahb(logic wr, logic [31:0] ad, logic [2:0] sz, logic [31:0] wd);
    @(negedge core_clk_in);
    hsel_in = 1'h1;
    htrans_in = 2'h2;
    hwrite_in = wr;
    haddr_in = ad;
    hsize_in = sz;
    @(negedge core_clk_in);
    htrans_in = 2'h0;
    hwdata_in = wd;
    ncyc = 0;
    while (hready_out !== 1'h1 && ncyc < 4000) begin
      @(negedge core_clk_in);
      ncyc++;
    end
    if (ncyc == 4000) begin
      n_mismatch++;
      print_verdict();
    end
    rd = hrdata_out;
    err = hresp_out;
  endtask
  initial begin
    void'($urandom(35130));
    cmd_act_high_in = 1'($urandom);
    dir_act_high_in = 1'($urandom);
    cs_act_high_in = 5'($urandom);
    rdy_rise_in = 1'h0;
    cfg(4'h2, 4'h3);
    repeat (3) @(posedge core_clk_in);
    @(negedge core_clk_in);
    arst_n_in = 1'h1;
    repeat (5) @(negedge core_clk_in);
    for (int k = 0; k < 6; k++) begin
      w = $urandom;
      a = 32'h0010_0000 + 32'($urandom % 64) * 32'h4;
      b = $urandom % 4;
      cfg(4'h2 + 4'($urandom % 3), 4'h3 + 4'($urandom % 13));
      ahb(1'h1, a, 3'h2, w);
      check("write resp", 32'h0, 32'(err));
      ahb(1'h0, a, 3'h2, 32'h0);
      check("word read", w, rd);
      ahb(1'h0, a + 32'(b), 3'h0, 32'h0);
      check("byte read", rep(w[8*b+:8]), rd);
    end
    ahb(1'h0, 32'h0080_0000, 3'h2, 32'h0);
    check("unmapped resp", 32'h1, 32'(err));
    ahb(1'h1, 32'h1010_0000, 3'h2, w);
    check("high space resp", 32'h1, 32'(err));
    rdy_en_in = 5'h02;
    ahb(1'h0, a, 3'h0, 32'h0);
    check("silent ready resp", 32'h1, 32'(err));
    for (int r = 0; r < 2; r++) begin
      rdy_rise_in = 1'(r);
      rdy_go = 1'h1;
      cfg(4'hf, 4'h3);
      ahb(1'h0, a, 3'h2, 32'h0);
      check("ready read", w, rd);
      check("ready early end", 32'h1, 32'(ncyc < 180));
    end
    rdy_en_in = 5'h00;
    rdy_go = 1'h0;
    nand_mode_in = 1'h1;
    ahb(1'h1, 32'h0040_0600, 3'h0, w);
    check("nand write resp", 32'h0, 32'(err));
    clk_en_in = 1'h0;
    clk_hiz_in = 1'h1;
    repeat (20) @(negedge core_clk_in);
    check("clock float", 32'h1, 32'(exp_clk_oe_n_out));
    check("clock off", 32'h0, 32'(exp_clk_out));
    print_verdict();
  end
endmodule

// [rtl/exp_clk_div.sv]
// Expansion clock divider producing the pin clock and a tick per period.
`include "ext_periph_bus_defines.svh"
module exp_clk_div (
  input  wire logic       core_clk_in,
  input  wire logic       arst_n_in,
  input  wire logic [3:0] div_in,
  input  wire logic       clk_en_in,
  input  wire logic       clk_hiz_in,
  output logic            exp_clk_out,
  output logic            exp_clk_oe_n_out,
  exp_timing_if.clk_src   tim
);
  logic [3:0] cnt;
  logic [3:0] div_eff;

  always_comb begin
    if (div_in < `EPB_DIV_MIN) begin
      div_eff = `EPB_DIV_MIN;
    end else begin
      div_eff = div_in;
    end
  end

  // Divide the system clock by an integer from three to fifteen.
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cnt <= 4'h0;
    end else if (cnt >= div_eff - 4'h1) begin
      cnt <= 4'h0;
    end else begin
      cnt <= cnt + 4'h1;
    end
  end

  assign tim.tick = (cnt == 4'h0);

  // Power down or float the pin clock on request.
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      exp_clk_out      <= 1'b0;
      exp_clk_oe_n_out <= 1'b1;
    end else begin
      exp_clk_out      <= clk_en_in && (cnt < {1'b0, div_eff[3:1]});
      exp_clk_oe_n_out <= clk_hiz_in;
    end
  end
endmodule

// [rtl/exp_timing_if.sv]
// Carrier for expansion clock ticks and ready detection events.
interface exp_timing_if;
  logic tick;
  logic rdy_evt;
  modport clk_src (output tick);
  modport rdy_src (output rdy_evt);
  modport ctrl    (input tick, input rdy_evt);
endinterface

// [rtl/ext_periph_bus_defines.svh]
// Constants for the external peripheral bus controller.
`ifndef EXT_PERIPH_BUS_DEFINES_SVH
`define EXT_PERIPH_BUS_DEFINES_SVH
`define EPB_NUM_CS       5
`define EPB_NAND_CS      3'h4
`define EPB_ADDR_W       26
`define EPB_DATA_W       16
`define EPB_DIV_MIN      4'h3
`define EPB_DIV_MAX      4'hf
`define EPB_SPACE_HI     31:28
`define EPB_SEG_FIELD    27:20
`define EPB_NAND_ALE_BIT 9
`define EPB_NAND_CLE_BIT 10
`define EPB_STRAP_WIDE   2'h1
`define EPB_SIZE_BYTE    2'h0
`define EPB_SIZE_HALF    2'h1
`define EPB_SIZE_WORD    2'h2
`define EPB_SYNC_LEN     2'h3
`endif

// [rtl/ext_periph_bus_pkg.sv]
// Types shared by the external peripheral bus controller.
package ext_periph_bus_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SETUP,
    ST_ALE,
    ST_GAP,
    ST_STROBE,
    ST_HOLD,
    ST_ERR1,
    ST_ERR2
  } epb_state_t;
endpackage

// [rtl/external_peripheral_bus_ctrl.sv]
// External peripheral bus controller bridging AHB to an 8/16-bit device bus.
// Function
// - Five selects: four generic plus NAND or fifth.
// - Twenty-six address bits, 64MB or 128MB per select.
// - Multiplexed mode reaches 256 or 64K locations.
// - Expansion clock is system clock divided 3-15.
// - Answers a window of up to 256 MB.
// - Byte-masked writes over at most two lanes.
// - Each select has its own active level.
// - Ready edge ends select and strobe early.
// - Ready edge direction is software selectable.
// - Counts in expansion ticks; clock off or floated.
// - Select zero boots at zero; straps set width.
// - Ready is synchronised before ending strobes.
// - Read data captured when strobe or select ends.
// - Per-select enable for ready detection.
// - Enabled ready never seen gives AHB error.
// - NAND uses address bits 9, 10 and own select.
// - NAND phases use dedicated strobes, held for the strobe width or until an enabled ready edge.
// - Strobe select bit picks separate or direction-plus-strobe.
// - Only the addressed select is asserted.
// - Writes split into beats; AHB stalls until done.
// - Byte reads and 16-bit-device halfword reads replicated across the 32-bit bus.
// - NAND correction engine lies outside this block.
// - Unmapped addresses receive an AHB error.
// - Address is used bits plus beat counter.
`include "ext_periph_bus_defines.svh"
module external_peripheral_bus_ctrl #(
  parameter int ADDR_W = `EPB_ADDR_W,
  parameter int DATA_W = `EPB_DATA_W,
  parameter int NUM_CS = `EPB_NUM_CS
) (
  input  wire logic               core_clk_in,
  input  wire logic               arst_n_in,
  input  wire logic               hsel_in,
  input  wire logic [31:0]        haddr_in,
  input  wire logic [1:0]         htrans_in,
  input  wire logic               hwrite_in,
  input  wire logic [2:0]         hsize_in,
  input  wire logic [31:0]        hwdata_in,
  input  wire logic               hready_in,
  output logic      [31:0]        hrdata_out,
  output logic                    hready_out,
  output logic                    hresp_out,
  input  wire logic [3:0]         clk_div_in,
  input  wire logic               clk_en_in,
  input  wire logic               clk_hiz_in,
  input  wire logic [NUM_CS*8-1:0] cs_base_in,
  input  wire logic [NUM_CS*8-1:0] cs_top_in,
  input  wire logic [NUM_CS-1:0]  cs_act_high_in,
  input  wire logic [NUM_CS-1:0]  wide16_in,
  input  wire logic [NUM_CS-1:0]  ale_mode_in,
  input  wire logic [NUM_CS-1:0]  strobe_select_bit_in,
  input  wire logic [NUM_CS-1:0]  rdy_en_in,
  input  wire logic               rdy_rise_in,
  input  wire logic               nand_mode_in,
  input  wire logic               cs4_en_in,
  input  wire logic               cmd_act_high_in,
  input  wire logic               dir_act_high_in,
  input  wire logic [3:0]         setup_cnt_in,
  input  wire logic [3:0]         width_cnt_in,
  input  wire logic [3:0]         hold_cnt_in,
  input  wire logic [1:0]         boot_width_in,
  input  wire logic               ready_in,
  input  wire logic [DATA_W-1:0]  data_in,
  output logic      [DATA_W-1:0]  data_out,
  output logic                    data_oe_n_out,
  output logic      [ADDR_W-1:0]  addr_out,
  output logic      [NUM_CS-1:0]  cs_out,
  output logic                    re_out,
  output logic                    we_out,
  output logic                    ale_out,
  output logic      [1:0]         byte_en_out,
  output logic                    nand_select_pin_out,
  output logic                    addr_latch_strobe_out,
  output logic                    cmd_latch_strobe_out,
  output logic                    nand_write_strobe_out,
  output logic                    nand_read_strobe_out,
  output logic                    exp_clk_out,
  output logic                    exp_clk_oe_n_out
);
  // ****************************************
  // Parameter checks and helpers
  // ****************************************
  if (ADDR_W != `EPB_ADDR_W || DATA_W != `EPB_DATA_W || NUM_CS != `EPB_NUM_CS) begin : g_chk
    $error("Unsupported bus geometry.");
  end

  exp_timing_if tim ();

  exp_clk_div u_div (
    .core_clk_in      (core_clk_in),
    .arst_n_in        (arst_n_in),
    .div_in           (clk_div_in),
    .clk_en_in        (clk_en_in),
    .clk_hiz_in       (clk_hiz_in),
    .exp_clk_out      (exp_clk_out),
    .exp_clk_oe_n_out (exp_clk_oe_n_out),
    .tim              (tim.clk_src)
  );

  rdy_detect u_rdy (
    .core_clk_in (core_clk_in),
    .arst_n_in   (arst_n_in),
    .ready_in    (ready_in),
    .rise_sel_in (rdy_rise_in),
    .tim         (tim.rdy_src)
  );

  ext_periph_bus_pkg::epb_state_t state;
  logic [3:0]        tcnt;
  logic [1:0]        beat;
  logic [27:0]       a_addr;
  logic [1:0]        a_size;
  logic              a_write;
  logic [31:0]       a_wdata;
  logic [2:0]        a_cs;
  logic              a_wide;
  logic              a_ale;
  logic              a_strb;
  logic              a_nand;
  logic              a_rdy;
  logic              err_pend;
  logic [DATA_W-1:0] d1;
  logic [DATA_W-1:0] d2;
  logic [1:0]        st1;
  logic [1:0]        st2;
  logic [1:0]        strap_cnt;
  logic              boot_wide;

  // ****************************************
  // Strap and data pin synchronisers
  // ****************************************
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      d1  <= '0;
      d2  <= '0;
      st1 <= 2'h0;
      st2 <= 2'h0;
    end else begin
      d1  <= data_in;
      d2  <= d1;
      st1 <= boot_width_in;
      st2 <= st1;
    end
  end

  // Catch the boot width straps once they have settled after reset.
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      strap_cnt <= 2'h0;
      boot_wide <= 1'b0;
    end else if (strap_cnt != `EPB_SYNC_LEN) begin
      strap_cnt <= strap_cnt + 2'h1;
      boot_wide <= (st2 == `EPB_STRAP_WIDE);
    end
  end

  // ****************************************
  // Address decode
  // ****************************************
  logic [NUM_CS-1:0] hit;
  logic [2:0]        sel;
  logic              any_hit;
  logic              start;

  always_comb begin
    for (int i = 0; i < NUM_CS; i++) begin
      hit[i] = (haddr_in[`EPB_SPACE_HI] == 4'h0) &&
               (haddr_in[`EPB_SEG_FIELD] >= cs_base_in[i*8 +: 8]) &&
               (haddr_in[`EPB_SEG_FIELD] <= cs_top_in[i*8 +: 8]);
    end
    hit[`EPB_NAND_CS] = hit[`EPB_NAND_CS] && (nand_mode_in || cs4_en_in);
  end

  // Pick the lowest matching select so only one is ever driven.
  always_comb begin
    sel     = 3'h0;
    any_hit = 1'b0;
    for (int i = NUM_CS - 1; i >= 0; i--) begin
      if (hit[i]) begin
        sel     = 3'(i);
        any_hit = 1'b1;
      end
    end
  end

  assign start = hsel_in && htrans_in[1] && hready_in && hready_out &&
                 (state == ext_periph_bus_pkg::ST_IDLE);

  // ****************************************
  // Beat geometry
  // ****************************************
  logic [1:0]        beats_m1;
  logic [ADDR_W-1:0] ext_addr;
  logic [1:0]        lane;
  logic [7:0]        wbyte;
  logic [15:0]       whalf;
  logic [3:0]        lim;
  logic              expire;

  always_comb begin
    if (a_wide) begin
      beats_m1 = (a_size == `EPB_SIZE_WORD) ? 2'h1 : 2'h0;
      lane     = (a_size == `EPB_SIZE_WORD) ? {beat[0], 1'b0} : {a_addr[1], 1'b0};
      if (a_size == `EPB_SIZE_WORD) begin
        ext_addr = {a_addr[26:2], beat[0]};
      end else begin
        ext_addr = a_addr[26:1];
      end
    end else begin
      case (a_size)
        `EPB_SIZE_BYTE: begin
          beats_m1 = 2'h0;
          ext_addr = a_addr[25:0];
          lane     = a_addr[1:0];
        end
        `EPB_SIZE_HALF: begin
          beats_m1 = 2'h1;
          ext_addr = {a_addr[25:1], beat[0]};
          lane     = {a_addr[1], beat[0]};
        end
        default: begin
          beats_m1 = 2'h3;
          ext_addr = {a_addr[25:2], beat};
          lane     = beat;
        end
      endcase
    end
    wbyte = a_wdata[lane*8 +: 8];
    whalf = a_wdata[lane[1]*16 +: 16];
  end

  always_comb begin
    case (state)
      ext_periph_bus_pkg::ST_STROBE: lim = width_cnt_in;
      ext_periph_bus_pkg::ST_HOLD:   lim = hold_cnt_in;
      default:                       lim = setup_cnt_in;
    endcase
    expire = tim.tick && (tcnt + 4'h1 >= lim);
  end

  // ****************************************
  // Transfer sequencer
  // ****************************************
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      a_addr  <= 28'h0;
      a_size  <= 2'h0;
      a_write <= 1'b0;
      a_cs    <= 3'h0;
      a_wide  <= 1'b0;
      a_ale   <= 1'b0;
      a_strb  <= 1'b0;
      a_nand  <= 1'b0;
      a_rdy   <= 1'b0;
    end else if (start) begin
      a_addr  <= haddr_in[27:0];
      a_size  <= (hsize_in[1]) ? `EPB_SIZE_WORD : hsize_in[1:0];
      a_write <= hwrite_in;
      a_cs    <= sel;
      a_wide  <= (sel == 3'h0) ? boot_wide : wide16_in[sel];
      a_ale   <= ale_mode_in[sel] && !(sel == `EPB_NAND_CS && nand_mode_in);
      a_strb  <= strobe_select_bit_in[sel];
      a_nand  <= (sel == `EPB_NAND_CS) && nand_mode_in;
      a_rdy   <= rdy_en_in[sel];
    end
  end

  // Write data arrives one cycle after the address phase.
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      a_wdata <= 32'h0;
    end else if (state == ext_periph_bus_pkg::ST_SETUP && tcnt == 4'h0 && beat == 2'h0) begin
      a_wdata <= hwdata_in;
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state    <= ext_periph_bus_pkg::ST_IDLE;
      tcnt     <= 4'h0;
      beat     <= 2'h0;
      err_pend <= 1'b0;
    end else begin
      case (state)
        ext_periph_bus_pkg::ST_IDLE: begin
          tcnt     <= 4'h0;
          beat     <= 2'h0;
          err_pend <= 1'b0;
          if (start) begin
            state <= any_hit ? ext_periph_bus_pkg::ST_SETUP : ext_periph_bus_pkg::ST_ERR1;
          end
        end
        ext_periph_bus_pkg::ST_SETUP, ext_periph_bus_pkg::ST_ALE,
        ext_periph_bus_pkg::ST_GAP: begin
          if (expire) begin
            tcnt <= 4'h0;
            if (state == ext_periph_bus_pkg::ST_SETUP && a_ale) begin
              state <= ext_periph_bus_pkg::ST_ALE;
            end else if (state == ext_periph_bus_pkg::ST_ALE) begin
              state <= ext_periph_bus_pkg::ST_GAP;
            end else begin
              state <= ext_periph_bus_pkg::ST_STROBE;
            end
          end else if (tim.tick) begin
            tcnt <= tcnt + 4'h1;
          end
        end
        ext_periph_bus_pkg::ST_STROBE: begin
          if (a_rdy && tim.rdy_evt) begin
            state    <= ext_periph_bus_pkg::ST_HOLD;
            tcnt     <= 4'h0;
          end else if (expire) begin
            err_pend <= err_pend || a_rdy;
            state    <= ext_periph_bus_pkg::ST_HOLD;
            tcnt     <= 4'h0;
          end else if (tim.tick) begin
            tcnt <= tcnt + 4'h1;
          end
        end
        ext_periph_bus_pkg::ST_HOLD: begin
          if (expire) begin
            tcnt <= 4'h0;
            if (beat == beats_m1) begin
              state <= err_pend ? ext_periph_bus_pkg::ST_ERR1 : ext_periph_bus_pkg::ST_IDLE;
            end else begin
              beat  <= beat + 2'h1;
              state <= ext_periph_bus_pkg::ST_SETUP;
            end
          end else if (tim.tick) begin
            tcnt <= tcnt + 4'h1;
          end
        end
        ext_periph_bus_pkg::ST_ERR1: state <= ext_periph_bus_pkg::ST_ERR2;
        default:                     state <= ext_periph_bus_pkg::ST_IDLE;
      endcase
    end
  end

  // ****************************************
  // AHB response
  // ****************************************
  logic last_done;
  assign last_done = (state == ext_periph_bus_pkg::ST_HOLD) && expire && (beat == beats_m1);

  // The AHB side waits until every beat has been sent.
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      hready_out <= 1'b1;
      hresp_out  <= 1'b0;
    end else if (start) begin
      hready_out <= 1'b0;
      hresp_out  <= 1'b0;
    end else if (last_done) begin
      hready_out <= !err_pend;
      hresp_out  <= 1'b0;
    end else if (state == ext_periph_bus_pkg::ST_ERR1) begin
      hready_out <= 1'b0;
      hresp_out  <= 1'b1;
    end else if (state == ext_periph_bus_pkg::ST_ERR2) begin
      hready_out <= 1'b1;
      hresp_out  <= 1'b1;
    end else if (state == ext_periph_bus_pkg::ST_IDLE) begin
      hready_out <= 1'b1;
      hresp_out  <= 1'b0;
    end
  end

  // Capture the bus on the cycle that ends the strobe and the select.
  logic strobe_end;
  assign strobe_end = (state == ext_periph_bus_pkg::ST_STROBE) &&
                      ((a_rdy && tim.rdy_evt) || expire);

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      hrdata_out <= 32'h0;
    end else if (strobe_end && !a_write) begin
      if (a_wide) begin
        if (a_size == `EPB_SIZE_WORD) begin
          hrdata_out[beat[0]*16 +: 16] <= d2;
        end else begin
          hrdata_out <= {2{d2}};
        end
      end else if (a_size == `EPB_SIZE_BYTE) begin
        hrdata_out <= {4{d2[7:0]}};
      end else begin
        hrdata_out[lane*8 +: 8] <= d2[7:0];
      end
    end
  end

  // ****************************************
  // Pin drive
  // ****************************************
  logic in_strobe;
  logic in_acc;
  logic in_ale;
  assign in_strobe = (state == ext_periph_bus_pkg::ST_STROBE) && !strobe_end;
  assign in_acc    = (state != ext_periph_bus_pkg::ST_IDLE) &&
                     (state != ext_periph_bus_pkg::ST_ERR1) &&
                     (state != ext_periph_bus_pkg::ST_ERR2);
  assign in_ale    = (state == ext_periph_bus_pkg::ST_ALE) ||
                     (state == ext_periph_bus_pkg::ST_GAP);

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      addr_out      <= '0;
      data_out      <= '0;
      data_oe_n_out <= 1'b1;
      ale_out       <= 1'b0;
      byte_en_out   <= 2'h0;
    end else begin
      addr_out    <= ext_addr;
      ale_out     <= (state == ext_periph_bus_pkg::ST_ALE);
      byte_en_out <= 2'h3;
      if (a_wide && a_size == `EPB_SIZE_BYTE) begin
        byte_en_out <= a_addr[0] ? 2'h2 : 2'h1;
      end
      if (in_ale) begin
        data_out      <= a_wide ? ext_addr[15:0] : {8'h0, ext_addr[7:0]};
        data_oe_n_out <= 1'b0;
      end else if (a_write && in_acc && state != ext_periph_bus_pkg::ST_SETUP) begin
        data_out      <= a_wide ? whalf : {8'h0, wbyte};
        data_oe_n_out <= 1'b0;
      end else begin
        data_oe_n_out <= 1'b1;
      end
    end
  end

  // Generic select and command pins with programmable levels.
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cs_out <= '0;
      re_out <= 1'b1;
      we_out <= 1'b1;
    end else begin
      for (int i = 0; i < NUM_CS; i++) begin
        cs_out[i] <= (in_strobe && !a_nand && a_cs == 3'(i)) ~^ cs_act_high_in[i];
      end
      if (a_strb) begin
        we_out <= (in_acc && !a_nand && !a_write) ~^ dir_act_high_in;
        re_out <= (in_strobe && !a_nand) ~^ cmd_act_high_in;
      end else begin
        we_out <= (in_strobe && !a_nand && a_write) ~^ cmd_act_high_in;
        re_out <= (in_strobe && !a_nand && !a_write) ~^ cmd_act_high_in;
      end
    end
  end

  // NAND phases drive dedicated strobes and latch strobes from address bits.
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      nand_select_pin_out   <= 1'b1;
      addr_latch_strobe_out <= 1'b0;
      cmd_latch_strobe_out  <= 1'b0;
      nand_write_strobe_out <= 1'b1;
      nand_read_strobe_out  <= 1'b1;
    end else begin
      nand_select_pin_out   <= !(in_acc && a_nand);
      addr_latch_strobe_out <= in_acc && a_nand && ext_addr[`EPB_NAND_ALE_BIT];
      cmd_latch_strobe_out  <= in_acc && a_nand && ext_addr[`EPB_NAND_CLE_BIT];
      nand_write_strobe_out <= !(in_strobe && a_nand && a_write);
      nand_read_strobe_out  <= !(in_strobe && a_nand && !a_write);
    end
  end
endmodule

// [rtl/rdy_detect.sv]
// Ready pin synchroniser with selectable edge detection.
module rdy_detect (
  input  wire logic core_clk_in,
  input  wire logic arst_n_in,
  input  wire logic ready_in,
  input  wire logic rise_sel_in,
  exp_timing_if.rdy_src tim
);
  logic s1;
  logic s2;
  logic s3;

  // Bring the ready pin onto the system clock before use.
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else begin
      s1 <= ready_in;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // Detect the rising or the falling edge as chosen.
  assign tim.rdy_evt = rise_sel_in ? (s2 && !s3) : (!s2 && s3);
endmodule
